// *** rtl/sensor_link_consts.vh ***
// Purpose: Constants for the single-wire sensor slave link
// Assumes: 200 MHz core clock
// Notes: Times in microseconds, counts in clock cycles
`ifndef SENSOR_LINK_CONSTS_VH
`define SENSOR_LINK_CONSTS_VH
`define CLK_MHZ 200
`define CMD_CONVERT 8'h44
`define CMD_READ_PAD 8'hbe
`define CMD_WRITE_PAD 8'h4e
`define CMD_COPY_PAD 8'h48
`define CMD_RELOAD 8'hb8
`define CMD_POWER_QUERY 8'hb4
`define PAD_BYTES 9
`define WR_BYTES 3
`define SAMPLE_US 30
`define SAMPLE_CYC (`SAMPLE_US * `CLK_MHZ)
`define HOLD_US 30
`define HOLD_CYC (`HOLD_US * `CLK_MHZ)
`define RESET_DET_US 400
`define RESET_DET_CYC (`RESET_DET_US * `CLK_MHZ)
`define PRES_WAIT_US 30
`define PRES_WAIT_CYC (`PRES_WAIT_US * `CLK_MHZ)
`define PRES_LOW_US 120
`define PRES_LOW_CYC (`PRES_LOW_US * `CLK_MHZ)
`define ST_IDLE 3'h0
`define ST_PRES_WAIT 3'h1
`define ST_PRES_LOW 3'h2
`define ST_CMD 3'h3
`define ST_READ_PAD 3'h4
`define ST_WRITE_PAD 3'h5
`define ST_STATUS 3'h6
`endif

// *** rtl/sensor_link_slave.v ***
// Purpose: Slave end of a single-wire open-drain sensor bus, function command layer
// Assumes: Command phase entered after presence; addressing handled elsewhere
// Notes: Scratchpad bytes and status come in from the sensor core as ports
`timescale 1ns/10ps
`include "sensor_link_consts.vh"
module sensor_link_slave #(
    parameter SAMPLE_CYCLES = `SAMPLE_CYC,
    parameter HOLD_CYCLES = `HOLD_CYC,
    parameter RESET_DET_CYCLES = `RESET_DET_CYC,
    parameter PRES_WAIT_CYCLES = `PRES_WAIT_CYC,
    parameter PRES_LOW_CYCLES = `PRES_LOW_CYC
) (
    input wire core_clk_in,
    input wire sys_rst_in,
    input wire bus_in,
    output wire bus_oe_n_out,
    output wire bus_out,
    input wire parasitic_in,
    input wire [71:0] pad_data_in,
    input wire conv_busy_in,
    input wire reload_busy_in,
    output reg conv_start_out,
    output reg copy_start_out,
    output reg reload_start_out,
    output reg [7:0] wr_data_out,
    output reg [1:0] wr_index_out,
    output reg wr_strobe_out,
    output reg presence_out
);
    localparam TW = 20;
    wire [TW-1:0] t_cnt;
    reg bus_d_r;
    reg [2:0] state_r;
    reg [7:0] shift_r;
    reg [6:0] bit_cnt_r;
    reg [1:0] byte_cnt_r;
    reg [1:0] status_src_r;
    reg drive_low_r;
    reg in_slot_r;
    reg sampled_r;
    reg reset_seen_r;
    wire fall = bus_d_r && !bus_in;
    wire rise = !bus_d_r && bus_in;
    reg tx_bit;

    // Timer restarts on every edge, so all windows are edge relative
    slot_timer #(.WIDTH(TW)) u_timer (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .restart_in(fall || rise),
        .count_out(t_cnt)
    );

    // Open drain: output low only, enable active low while pulling
    assign bus_out = 1'b0;
    assign bus_oe_n_out = !drive_low_r;

    always @* begin
        tx_bit = 1'b1;
        case (status_src_r)
            2'h1: tx_bit = !conv_busy_in;
            2'h2: tx_bit = !reload_busy_in;
            2'h3: tx_bit = !parasitic_in;
            default: tx_bit = pad_data_in[bit_cnt_r];
        endcase
    end

    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            bus_d_r <= 1'b1;
            state_r <= `ST_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 7'h00;
            byte_cnt_r <= 2'h0;
            status_src_r <= 2'h0;
            drive_low_r <= 1'b0;
            in_slot_r <= 1'b0;
            sampled_r <= 1'b0;
            reset_seen_r <= 1'b0;
            conv_start_out <= 1'b0;
            copy_start_out <= 1'b0;
            reload_start_out <= 1'b0;
            wr_data_out <= 8'h00;
            wr_index_out <= 2'h0;
            wr_strobe_out <= 1'b0;
            presence_out <= 1'b0;
        end else begin
            bus_d_r <= bus_in;
            conv_start_out <= 1'b0;
            copy_start_out <= 1'b0;
            reload_start_out <= 1'b0;
            wr_strobe_out <= 1'b0;
            presence_out <= 1'b0;
            // Long low means reset from master, whatever the state
            if (!bus_in && !drive_low_r && t_cnt == RESET_DET_CYCLES[TW-1:0]) begin
                reset_seen_r <= 1'b1;
                state_r <= `ST_IDLE;
                in_slot_r <= 1'b0;
            end
            if (reset_seen_r && rise) begin
                reset_seen_r <= 1'b0;
                drive_low_r <= 1'b0;
                state_r <= `ST_PRES_WAIT;
            end else begin
                case (state_r)
                    `ST_PRES_WAIT: begin
                        if (t_cnt == PRES_WAIT_CYCLES[TW-1:0]) begin
                            drive_low_r <= 1'b1;
                            presence_out <= 1'b1;
                            state_r <= `ST_PRES_LOW;
                        end
                    end
                    `ST_PRES_LOW: begin
                        // Own falling edge restarts the timer at the pull
                        if (t_cnt == PRES_LOW_CYCLES[TW-1:0]) begin
                            drive_low_r <= 1'b0;
                            state_r <= `ST_CMD;
                            bit_cnt_r <= 7'h00;
                        end
                    end
                    `ST_CMD, `ST_WRITE_PAD: begin
                        if (fall) begin
                            in_slot_r <= 1'b1;
                            sampled_r <= 1'b0;
                        end else if (in_slot_r && !sampled_r && t_cnt == SAMPLE_CYCLES[TW-1:0]) begin
                            // Sampled mid-window; one bit per slot
                            sampled_r <= 1'b1;
                            in_slot_r <= 1'b0;
                            shift_r <= {bus_in, shift_r[7:1]};
                            bit_cnt_r <= bit_cnt_r + 7'h01;
                            if (bit_cnt_r[2:0] == 3'h7) begin
                                bit_cnt_r <= 7'h00;
                                if (state_r == `ST_WRITE_PAD) begin
                                    wr_data_out <= {bus_in, shift_r[7:1]};
                                    wr_index_out <= byte_cnt_r;
                                    wr_strobe_out <= 1'b1;
                                    byte_cnt_r <= byte_cnt_r + 2'h1;
                                    if (byte_cnt_r == 2'h2) begin
                                        state_r <= `ST_IDLE;
                                    end
                                end else begin
                                    case ({bus_in, shift_r[7:1]})
                                        `CMD_CONVERT: begin
                                            conv_start_out <= 1'b1;
                                            status_src_r <= 2'h1;
                                            state_r <= parasitic_in ? `ST_IDLE : `ST_STATUS;
                                        end
                                        `CMD_READ_PAD: begin
                                            status_src_r <= 2'h0;
                                            state_r <= `ST_READ_PAD;
                                        end
                                        `CMD_WRITE_PAD: begin
                                            byte_cnt_r <= 2'h0;
                                            state_r <= `ST_WRITE_PAD;
                                        end
                                        `CMD_COPY_PAD: begin
                                            copy_start_out <= 1'b1;
                                            state_r <= `ST_IDLE;
                                        end
                                        `CMD_RELOAD: begin
                                            reload_start_out <= 1'b1;
                                            status_src_r <= 2'h2;
                                            state_r <= `ST_STATUS;
                                        end
                                        `CMD_POWER_QUERY: begin
                                            status_src_r <= 2'h3;
                                            state_r <= `ST_STATUS;
                                        end
                                        default: state_r <= `ST_IDLE;
                                    endcase
                                end
                            end
                        end
                    end
                    `ST_READ_PAD, `ST_STATUS: begin
                        if (fall && !drive_low_r) begin
                            // Only a master falling edge opens a read slot
                            drive_low_r <= !tx_bit;
                            in_slot_r <= 1'b1;
                        end else if (in_slot_r && t_cnt == HOLD_CYCLES[TW-1:0]) begin
                            // Our own low hides the master release, so for a zero bit the timer runs from the master fall; for a one bit it runs from the release
                            drive_low_r <= 1'b0;
                            in_slot_r <= 1'b0;
                            if (state_r == `ST_READ_PAD) begin
                                if (bit_cnt_r == 7'd71) begin
                                    state_r <= `ST_IDLE;
                                end else begin
                                    bit_cnt_r <= bit_cnt_r + 7'h01;
                                end
                            end
                        end
                    end
                    default: begin
                        drive_low_r <= 1'b0;
                        in_slot_r <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// *** rtl/slot_timer.v ***
// Purpose: Cycle counter measuring time since the last bus edge
// Assumes: Restart pulses on each detected edge
// Notes: Saturates so it never wraps back into a window
`timescale 1ns/10ps
module slot_timer #(
    parameter WIDTH = 20
) (
    input wire core_clk_in,
    input wire sys_rst_in,
    input wire restart_in,
    output reg [WIDTH-1:0] count_out
);
    always @(posedge core_clk_in) begin
        if (sys_rst_in || restart_in) begin
            count_out <= {WIDTH{1'b0}};
        end else if (count_out != {WIDTH{1'b1}}) begin
            count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

// *** testbench/bus_master_model.sv ***
// Purpose: Behavioural bus master with pull-up on the shared line
// Assumes: Slave timing parameters 20/20/200/20/40 cycles
// Notes: Never drives during parasitic busy periods
`timescale 1ns/10ps
module bus_master_model (
    input wire core_clk_in,
    input wire bus_oe_n_in,
    output wire bus_level_out
);
    logic drive_low = 1'b0;
    // Pull-up wins only when nobody pulls low
    assign bus_level_out = !(drive_low || !bus_oe_n_in);
    task automatic hold(input integer n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic reset_pulse;
        drive_low = 1'b1;
        hold(250);
        drive_low = 1'b0;
    endtask
    task automatic write_bit(input logic b);
        drive_low = 1'b1;
        hold(3);
        drive_low = !b;
        hold(37);
        drive_low = 1'b0;
        hold(3);
    endtask
    task automatic write_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) write_bit(v[i]);
    endtask
    task automatic read_bit(output logic b);
        drive_low = 1'b1;
        hold(3);
        drive_low = 1'b0;
        hold(8);
        b = bus_level_out;
        hold(32);
    endtask
endmodule

// *** testbench/link_chk.sv ***
// Purpose: Port-level timing checks for the sensor link slave
// Assumes: One clock domain, synchronous reset
// Notes: Long intervals are held in a helper counter
`timescale 1ns/10ps
module link_chk #(
    parameter PRES_LOW_CYCLES = 24000
) (
    input wire core_clk_in,
    input wire sys_rst_in,
    input wire bus_in,
    input wire bus_oe_n_out,
    input wire bus_out,
    input wire presence_out,
    input wire conv_start_out,
    input wire copy_start_out,
    input wire reload_start_out,
    input wire wr_strobe_out,
    input wire [1:0] wr_index_out
);
    reg [19:0] low_cnt_r;
    always @(posedge core_clk_in) begin
        if (sys_rst_in || bus_oe_n_out)
            low_cnt_r <= 20'h0;
        else
            low_cnt_r <= low_cnt_r + 20'h1;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_od; bus_out == 1'b0; endproperty
    a_od: assert property (p_od) else $error("data pin not held at zero");
    property p_pull; !bus_oe_n_out |-> !bus_in; endproperty
    a_pull: assert property (p_pull) else $error("driven low but bus high");
    property p_pres; presence_out |-> ##[0:2] !bus_oe_n_out; endproperty
    a_pres: assert property (p_pres) else $error("presence without pull");
    // Counter bound catches a pull that never lets go
    property p_pres_len; low_cnt_r <= PRES_LOW_CYCLES + 2; endproperty
    a_pres_len: assert property (p_pres_len) else $error("pull held too long");
    property p_cause;
        $fell(bus_oe_n_out) |-> presence_out || $past(presence_out) || (!$past(bus_in) && $past(bus_in, 2));
    endproperty
    a_cause: assert property (p_cause) else $error("pull without slot start");
    property p_conv; conv_start_out |-> !copy_start_out && !reload_start_out ##1 !conv_start_out; endproperty
    a_conv: assert property (p_conv) else $error("bad convert pulse");
    property p_copy; copy_start_out |=> !copy_start_out; endproperty
    a_copy: assert property (p_copy) else $error("bad copy pulse");
    property p_reload; reload_start_out |=> !reload_start_out; endproperty
    a_reload: assert property (p_reload) else $error("bad reload pulse");
    property p_wr; wr_strobe_out |-> wr_index_out < 2'h3 ##1 !wr_strobe_out; endproperty
    a_wr: assert property (p_wr) else $error("bad write strobe");
endmodule
bind sensor_link_slave link_chk #(.PRES_LOW_CYCLES(PRES_LOW_CYCLES)) link_chk_inst (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .bus_in(bus_in), .bus_oe_n_out(bus_oe_n_out), .bus_out(bus_out),
    .presence_out(presence_out), .conv_start_out(conv_start_out), .copy_start_out(copy_start_out),
    .reload_start_out(reload_start_out), .wr_strobe_out(wr_strobe_out), .wr_index_out(wr_index_out));

// *** testbench/sensor_link_slave_bench.sv ***
// Purpose: Self-checking bench for the sensor link slave
// Assumes: Shortened interval parameters
// Notes: Slave bits checked at the master sample point
`timescale 1ns/10ps
module sensor_link_slave_bench;
    logic core_clk_in = 1'b0, sys_rst_in = 1'b1, parasitic_in = 1'b0, conv_busy_in = 1'b0, reload_busy_in = 1'b0;
    logic [71:0] pad_data_in = 72'hc7_9e_10_4b_46_7f_a5_0f_3c;
    wire bus, oe_n, bus_out, presence_out, conv_s, copy_s, reload_s, wr_strobe_out;
    wire [7:0] wr_data_out;
    wire [1:0] wr_index_out;
    integer mismatches = 0, check_count = 0, start_n[0:2] = '{0, 0, 0};
    logic [23:0] wr_seen = 24'h0;
    logic b;
    sensor_link_slave #(.SAMPLE_CYCLES(20), .HOLD_CYCLES(20), .RESET_DET_CYCLES(200), .PRES_WAIT_CYCLES(20),
        .PRES_LOW_CYCLES(40)) sensor_link_slave_inst (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .bus_in(bus), .bus_oe_n_out(oe_n), .bus_out(bus_out), .parasitic_in(parasitic_in),
        .pad_data_in(pad_data_in), .conv_busy_in(conv_busy_in), .reload_busy_in(reload_busy_in),
        .conv_start_out(conv_s), .copy_start_out(copy_s), .reload_start_out(reload_s),
        .wr_data_out(wr_data_out), .wr_index_out(wr_index_out), .wr_strobe_out(wr_strobe_out),
        .presence_out(presence_out));
    bus_master_model m (.core_clk_in(core_clk_in), .bus_oe_n_in(oe_n), .bus_level_out(bus));
    initial begin
        forever #2.5 core_clk_in = !core_clk_in;
    end
    always @(posedge core_clk_in) begin
        start_n[0] <= start_n[0] + conv_s;
        start_n[1] <= start_n[1] + copy_s;
        start_n[2] <= start_n[2] + reload_s;
        if (wr_strobe_out)
            wr_seen[wr_index_out * 8 +: 8] <= wr_data_out;
    end
    task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic init_seq;
        m.reset_pulse();
        m.hold(10);
        check("pre presence", 1, bus);
        m.hold(30);
        check("presence", 0, bus);
        m.hold(40);
        check("after presence", 1, bus);
    endtask
    task automatic cmd(input logic [7:0] c);
        init_seq();
        m.write_byte(c);
    endtask
    task automatic t_read_pad(input logic [71:0] pat);
        logic [71:0] got;
        pad_data_in = pat;
        cmd(8'hbe);
        for (int i = 0; i < 72; i++) m.read_bit(got[i]);
        check("pad", pad_data_in, got);
        m.read_bit(b);
        check("after pad", 1, b);
    endtask
    task automatic t_abort;
        logic [7:0] got;
        cmd(8'hbe);
        for (int i = 0; i < 8; i++) m.read_bit(got[i]);
        check("byte0", pad_data_in[7:0], got);
        init_seq();
        m.read_bit(b);
        check("no command", 1, b);
    endtask
    task automatic t_write;
        integer n0;
        n0 = start_n[0];
        cmd(8'h4e);
        m.write_byte(8'h5a);
        m.write_byte(8'ha3);
        m.write_byte(8'h0f);
        check("wr bytes", 24'h0fa35a, wr_seen);
        check("wr no start", n0, start_n[0]);
    endtask
    // Busy is raised before convert and reload so their first status slot must read zero; copy gives no status and reads one
    task automatic t_start(input logic [7:0] c, input integer k);
        integer n0;
        n0 = start_n[k];
        conv_busy_in = (k == 0);
        reload_busy_in = (k == 2);
        cmd(c);
        m.read_bit(b);
        check("busy slot", k == 1, b);
        conv_busy_in = 1'b0;
        reload_busy_in = 1'b0;
        m.read_bit(b);
        check("done slot", 1, b);
        check("start pulses", n0 + 1, start_n[k]);
    endtask
    task automatic t_power;
        for (int p = 0; p < 2; p++) begin
            parasitic_in = p[0];
            cmd(8'hb4);
            m.read_bit(b);
            check("power", !p[0], b);
        end
    endtask
    // Parasitic convert gives no status; line stays quiet until the conversion is over
    task automatic t_park_convert;
        integer n0;
        n0 = start_n[0];
        parasitic_in = 1'b1;
        conv_busy_in = 1'b1;
        cmd(8'h44);
        m.hold(100);
        check("parasitic start", n0 + 1, start_n[0]);
        check("parasitic quiet", 1, bus);
        conv_busy_in = 1'b0;
        m.read_bit(b);
        check("parasitic no status", 1, b);
        parasitic_in = 1'b0;
    endtask
    task automatic complete_run;
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (6) @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        m.hold(5);
        check("idle", 1, bus);
        t_read_pad(72'hc7_9e_10_4b_46_7f_a5_0f_3c);
        t_read_pad(72'h38_61_ef_b4_b9_80_5a_f0_c3);
        t_abort();
        t_write();
        t_start(8'h44, 0);
        t_start(8'h48, 1);
        t_start(8'hb8, 2);
        t_power();
        t_park_convert();
        complete_run();
    end
endmodule
